// ### hw/tcc_pkg.sv
package tcc_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_CCR = 8'h00;
  localparam logic [7:0] OFF_CMR = 8'h04;
  localparam logic [7:0] OFF_CV = 8'h10;
  localparam logic [7:0] OFF_RA = 8'h14;
  localparam logic [7:0] OFF_RB = 8'h18;
  localparam logic [7:0] OFF_RC = 8'h1C;
  localparam logic [7:0] OFF_SR = 8'h20;
  localparam logic [7:0] OFF_IER = 8'h24;
  localparam logic [7:0] OFF_IDR = 8'h28;
  localparam logic [7:0] OFF_IMR = 8'h2C;
  localparam logic [7:0] OFF_BCR = 8'hC0;
  localparam logic [7:0] OFF_BMR = 8'hC4;
  // ****************************************
  // Reset values and counter maximum
  // ****************************************
  localparam logic [31:0] RST_CMR = 32'h00000000;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [5:0] RST_FLAGS = 6'h00;
  localparam logic [2:0] RST_BMR = 3'h0;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // ****************************************
  // Command bits (channel and block)
  // ****************************************
  localparam int CCR_EN = 0;
  localparam int CCR_DIS = 1;
  localparam int CCR_SOFT_TRIGGER_CMD = 2;
  localparam int BCR_SYNC = 0;
  // ****************************************
  // Mode setting fields
  // ****************************************
  localparam int CMR_CLKS = 0;
  localparam int CMR_INV = 3;
  localparam int CMR_BURST = 4;
  localparam int CMR_STOP = 6;
  localparam int CMR_DIS = 7;
  localparam int CMR_EDG = 8;
  localparam int CMR_EVSEL = 10;
  localparam int CMR_EXT_EVENT_TRIGGER_ENABLE = 12;
  localparam int CMR_COMPARE_C_TRIGGER_ENABLE = 14;
  localparam int CMR_WAVE = 15;
  localparam int CMR_LDA = 16;
  localparam int CMR_LDB = 18;
  localparam logic [31:0] CMR_MASK = 32'h000FDFFF;
  // ****************************************
  // Status bits
  // ****************************************
  localparam int SR_OVF = 0;
  localparam int SR_LOVR = 1;
  localparam int SR_CPC = 2;
  localparam int SR_LDA = 3;
  localparam int SR_LDB = 4;
  localparam int SR_ETRG = 5;
  localparam int SR_COUNTING_ENABLED_FLAG = 16;
  localparam int SR_LINEA = 17;
  localparam int SR_LINEB = 18;
  // ****************************************
  // Internal clock prescaler taps and edge select codes
  // ****************************************
  localparam int PRE_W = 10;
  localparam int TAP1 = 0;
  localparam int TAP2 = 2;
  localparam int TAP3 = 4;
  localparam int TAP4 = 6;
  localparam int TAP5 = 9;
  localparam logic [1:0] EDGE_NONE = 2'd0;
  localparam logic [1:0] EDGE_RISE = 2'd1;
  localparam logic [1:0] EDGE_FALL = 2'd2;
endpackage : tcc_pkg

// ### hw/tcc_channel.sv
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ns
module tcc_channel
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External clocks and chaining
  input wire logic [2:0] ext_clock_pins,
  input wire logic [2:0] chain_line_a,
  // Line A and line B
  input wire logic line_a_in,
  input wire logic line_a_event,
  output logic line_a_out,
  output logic line_a_oe,
  input wire logic line_b_in,
  output logic line_b_out,
  output logic line_b_oe,
  // Interrupt
  output logic irq
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic edge_match(input logic [1:0] sel, input logic rise,
                                      input logic fall);
    case (sel)
      EDGE_NONE: edge_match = 1'b0;
      EDGE_RISE: edge_match = rise;
      EDGE_FALL: edge_match = fall;
      default: edge_match = rise | fall;
    endcase
  endfunction : edge_match

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      OFF_CCR, OFF_CMR, OFF_CV, OFF_RA, OFF_RB, OFF_RC, OFF_SR,
      OFF_IER, OFF_IDR, OFF_IMR, OFF_BCR, OFF_BMR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  // ****************************************
  // State
  // ****************************************
  logic pready_reg, pslverr_reg, irq_reg;
  logic [31:0] prdata_reg, rdata_next;
  logic [31:0] cmr_reg;
  logic [2:0] bmr_reg;
  logic [15:0] cnt_reg, ra_reg, rb_reg, rc_reg;
  logic [5:0] sr_reg, sr_next, imr_reg;
  logic [PRE_W-1:0] pre_reg;
  logic clk_en_reg, clk_run_reg, trig_pend_reg, wait_b_reg;
  logic ra_unread_reg, rb_unread_reg, cnt_upd_reg;
  logic sel_prev_reg, la_prev_reg;
  logic [3:0] ev_prev_reg;
  logic la_oe_reg, lb_oe_reg;

  // ****************************************
  // Bus decode
  // ****************************************
  logic access, wr, rd;
  assign access = psel & penable & pready_reg;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;

  logic sw_trig, sync_trig, cmd_en, cmd_dis;
  assign cmd_en = wr & (paddr == OFF_CCR) & pwdata[CCR_EN];
  assign cmd_dis = wr & (paddr == OFF_CCR) & pwdata[CCR_DIS];
  assign sw_trig = wr & (paddr == OFF_CCR) & pwdata[CCR_SOFT_TRIGGER_CMD];
  assign sync_trig = wr & (paddr == OFF_BCR) & pwdata[BCR_SYNC];

  // ****************************************
  // Mode fields
  // ****************************************
  logic wave, inv, ab_sel, ext_event_trigger_enable, compare_c_trigger_enable, stop_ev_en, dis_ev_en;
  logic [2:0] clk_sel;
  logic [1:0] burst, edg, evsel, lda_sel, ldb_sel;
  assign wave = cmr_reg[CMR_WAVE];
  assign clk_sel = cmr_reg[CMR_CLKS +: 3];
  assign inv = cmr_reg[CMR_INV];
  assign burst = cmr_reg[CMR_BURST +: 2];
  assign stop_ev_en = cmr_reg[CMR_STOP];
  assign dis_ev_en = cmr_reg[CMR_DIS];
  assign edg = cmr_reg[CMR_EDG +: 2];
  assign ab_sel = cmr_reg[CMR_EVSEL];
  assign evsel = cmr_reg[CMR_EVSEL +: 2];
  assign ext_event_trigger_enable = cmr_reg[CMR_EXT_EVENT_TRIGGER_ENABLE];
  assign compare_c_trigger_enable = cmr_reg[CMR_COMPARE_C_TRIGGER_ENABLE];
  assign lda_sel = cmr_reg[CMR_LDA +: 2];
  assign ldb_sel = cmr_reg[CMR_LDB +: 2];

  // ****************************************
  // Clock selection
  // ****************************************
  logic [2:0] xc;
  logic [7:0] clk_src;
  logic sel_lvl, gate, valid_edge;
  assign xc = (bmr_reg & chain_line_a) | (~bmr_reg & ext_clock_pins);
  assign clk_src = {xc, pre_reg[TAP5], pre_reg[TAP4], pre_reg[TAP3], pre_reg[TAP2],
                    pre_reg[TAP1]};
  assign sel_lvl = clk_src[clk_sel] ^ inv;
  assign gate = (burst == 2'd0) ? 1'b1 : xc[burst - 2'd1];
  assign valid_edge = sel_lvl & ~sel_prev_reg & gate & clk_run_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= '0;
      sel_prev_reg <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
      sel_prev_reg <= sel_lvl;
    end
  end

  // ****************************************
  // Line edges and triggers
  // ****************************************
  logic la, la_rise, la_fall, ext_trig, cpc_hit, any_trig;
  logic [3:0] ev_lvl;
  logic ev_rise, ev_fall, cap_rise, cap_fall;
  assign la = line_a_in | line_a_event;
  assign la_rise = la & ~la_prev_reg;
  assign la_fall = ~la & la_prev_reg;
  assign ev_lvl = {xc, line_b_in};
  assign ev_rise = ev_lvl[evsel] & ~ev_prev_reg[evsel];
  assign ev_fall = ~ev_lvl[evsel] & ev_prev_reg[evsel];
  assign cap_rise = ab_sel ? la_rise : (line_b_in & ~ev_prev_reg[0]);
  assign cap_fall = ab_sel ? la_fall : (~line_b_in & ev_prev_reg[0]);
  always_comb begin
    if (wave) begin
      ext_trig = ext_event_trigger_enable & edge_match(edg, ev_rise, ev_fall);
    end else begin
      ext_trig = edge_match(edg, cap_rise, cap_fall);
    end
  end
  assign cpc_hit = cnt_upd_reg & (cnt_reg == rc_reg);
  assign any_trig = sw_trig | sync_trig | ext_trig | (compare_c_trigger_enable & cpc_hit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      la_prev_reg <= 1'b0;
      ev_prev_reg <= '0;
    end else begin
      la_prev_reg <= la;
      ev_prev_reg <= ev_lvl;
    end
  end

  // ****************************************
  // Capture loading
  // ****************************************
  logic ld_a, ld_b, cap_stop;
  assign ld_a = ~wave & edge_match(lda_sel, la_rise, la_fall) & ~wait_b_reg;
  assign ld_b = ~wave & edge_match(ldb_sel, la_rise, la_fall) & wait_b_reg;
  assign cap_stop = wave ? cpc_hit : ld_b;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_b_reg <= 1'b0;
    end else if (any_trig) begin
      wait_b_reg <= 1'b0;
    end else if (ld_a) begin
      wait_b_reg <= 1'b1;
    end else if (ld_b) begin
      wait_b_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ra_unread_reg <= 1'b0;
      rb_unread_reg <= 1'b0;
    end else begin
      ra_unread_reg <= ld_a | (ra_unread_reg & ~(rd & (paddr == OFF_RA)));
      rb_unread_reg <= ld_b | (rb_unread_reg & ~(rd & (paddr == OFF_RB)));
    end
  end

  // ****************************************
  // Clock control
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en_reg <= 1'b0;
    end else if (cmd_dis | (dis_ev_en & cap_stop)) begin
      clk_en_reg <= 1'b0;
    end else if (cmd_en) begin
      clk_en_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_run_reg <= 1'b0;
    end else if (!clk_en_reg | cmd_dis | (dis_ev_en & cap_stop)) begin
      clk_run_reg <= 1'b0;
    end else if (any_trig) begin
      clk_run_reg <= 1'b1;
    end else if (stop_ev_en & cap_stop) begin
      clk_run_reg <= 1'b0;
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_pend_reg <= 1'b0;
    end else if (any_trig) begin
      trig_pend_reg <= 1'b1;
    end else if (valid_edge) begin
      trig_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= RST_WORD;
      cnt_upd_reg <= 1'b0;
    end else begin
      cnt_upd_reg <= valid_edge;
      if (valid_edge) begin
        cnt_reg <= trig_pend_reg ? RST_WORD : cnt_reg + 16'h0001;
      end
    end
  end

  // ****************************************
  // Status flags (set wins over read clear)
  // ****************************************
  always_comb begin
    sr_next = (rd & (paddr == OFF_SR)) ? RST_FLAGS : sr_reg;
    if (valid_edge & ~trig_pend_reg & (cnt_reg == CNT_MAX)) begin
      sr_next[SR_OVF] = 1'b1;
    end
    if ((ld_a & ra_unread_reg) | (ld_b & rb_unread_reg)) begin
      sr_next[SR_LOVR] = 1'b1;
    end
    if (cpc_hit) begin
      sr_next[SR_CPC] = 1'b1;
    end
    if (ld_a) begin
      sr_next[SR_LDA] = 1'b1;
    end
    if (ld_b) begin
      sr_next[SR_LDB] = 1'b1;
    end
    if (ext_trig) begin
      sr_next[SR_ETRG] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_reg <= RST_FLAGS;
    end else begin
      sr_reg <= sr_next;
    end
  end

  // ****************************************
  // Writable registers and captures
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmr_reg <= RST_CMR;
      bmr_reg <= RST_BMR;
      rc_reg <= RST_WORD;
      imr_reg <= RST_FLAGS;
    end else if (wr) begin
      case (paddr)
        OFF_CMR: cmr_reg <= pwdata & CMR_MASK;
        OFF_BMR: bmr_reg <= pwdata[2:0];
        OFF_RC: rc_reg <= pwdata[15:0];
        OFF_IER: imr_reg <= imr_reg | pwdata[5:0];
        OFF_IDR: imr_reg <= imr_reg & ~pwdata[5:0];
        default: imr_reg <= imr_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ra_reg <= RST_WORD;
      rb_reg <= RST_WORD;
    end else begin
      if (ld_a) begin
        ra_reg <= cnt_reg;
      end else if (wr & wave & (paddr == OFF_RA)) begin
        ra_reg <= pwdata[15:0];
      end
      if (ld_b) begin
        rb_reg <= cnt_reg;
      end else if (wr & wave & (paddr == OFF_RB)) begin
        rb_reg <= pwdata[15:0];
      end
    end
  end

  // ****************************************
  // APB answer
  // ****************************************
  always_comb begin
    rdata_next = '0;
    case (paddr)
      OFF_CMR: rdata_next = cmr_reg;
      OFF_CV: rdata_next[15:0] = cnt_reg;
      OFF_RA: rdata_next[15:0] = ra_reg;
      OFF_RB: rdata_next[15:0] = rb_reg;
      OFF_RC: rdata_next[15:0] = rc_reg;
      OFF_SR: begin
        rdata_next[5:0] = sr_reg;
        rdata_next[SR_COUNTING_ENABLED_FLAG] = clk_en_reg;
        rdata_next[SR_LINEA] = la;
        rdata_next[SR_LINEB] = line_b_in;
      end
      OFF_IMR: rdata_next[5:0] = imr_reg;
      OFF_BMR: rdata_next[2:0] = bmr_reg;
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~mapped(paddr);
      prdata_reg <= (psel & penable & ~pready_reg & ~pwrite) ? rdata_next : '0;
    end
  end

  // ****************************************
  // Pin directions and interrupt
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      la_oe_reg <= 1'b0;
      lb_oe_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      la_oe_reg <= wave;
      lb_oe_reg <= wave & ~((evsel == 2'd0) & ext_event_trigger_enable & (edg != EDGE_NONE));
      irq_reg <= |(sr_next & imr_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign line_a_out = 1'b0;
  assign line_b_out = 1'b0;
  assign line_a_oe = la_oe_reg;
  assign line_b_oe = lb_oe_reg;
  assign irq = irq_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ovf_flag_a: assert property (valid_edge & ~trig_pend_reg & (cnt_reg == CNT_MAX)
    |=> sr_reg[SR_OVF] && cnt_reg == RST_WORD) else $error("overflow missed");
  trig_clear_a: assert property (valid_edge & trig_pend_reg |=> cnt_reg == RST_WORD)
    else $error("trigger did not clear counter");
  cnt_step_a: assert property (valid_edge & ~trig_pend_reg
    |=> cnt_reg == $past(cnt_reg) + 16'h0001) else $error("counter step wrong");
  run_gate_a: assert property (!clk_en_reg |=> !clk_run_reg)
    else $error("clock runs while disabled");
  trig_start_a: assert property (any_trig & clk_en_reg & ~cmd_dis & ~(dis_ev_en & cap_stop)
    |=> clk_run_reg && trig_pend_reg) else $error("trigger did not start");
  sync_trig_a: assert property (sync_trig |=> trig_pend_reg)
    else $error("group trigger lost");
  cap_order_a: assert property (ld_a & ~any_trig |=> wait_b_reg && ra_reg == $past(cnt_reg))
    else $error("capture A order wrong");
  overrun_a: assert property (ld_b & rb_unread_reg |=> sr_reg[SR_LOVR])
    else $error("overrun not flagged");
  pin_dir_a: assert property (!wave ##1 !wave |-> !line_a_oe && !line_b_oe)
    else $error("line driven in capture");
  irq_out_a: assert property (|(sr_reg & imr_reg) & ~(rd & (paddr == OFF_SR)) |=> irq)
    else $error("interrupt missing");

  trig_cov_c: cover property (any_trig ##[1:20] valid_edge);
  cap_pair_c: cover property (ld_a ##[1:200] ld_b);
  ovf_cov_c: cover property (sr_reg[SR_OVF]);
  lovr_cov_c: cover property (sr_reg[SR_LOVR]);
endmodule : tcc_channel

// ### verification/tcc_far.sv
`timescale 1ns/1ns
// ********
// Far side: clock pins, chain lines, line sources
// ********
module tcc_far (
  // Clock
  input wire logic pclk,
  // Lines towards the channel
  output logic [2:0] ext_clock_pins,
  output logic [2:0] chain_line_a,
  output logic line_a_pin,
  output logic line_a_event,
  output logic line_b_pin
);
  logic [8:0] far = 9'h000;
  assign ext_clock_pins = far[2:0];
  assign chain_line_a = far[5:3];
  assign line_a_pin = far[6];
  assign line_b_pin = far[7];
  assign line_a_event = far[8];
  // One source at a time, each pulse level held two bus clocks, a set level four
  task pulse(input int b, input int n);
    repeat (n) begin
      far[b] <= 1'b1;
      repeat (2) @(posedge pclk);
      far[b] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask : pulse
  task level(input int b, input logic v);
    far[b] <= v;
    repeat (4) @(posedge pclk);
  endtask : level
endmodule : tcc_far

// ### verification/tcc_channel_tb_top.sv
`timescale 1ns/1ns
module tcc_channel_tb_top
  import tcc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0] ext_pins, chain;
  logic a_pin, a_event, b_pin, a_out, a_oe, b_out, b_oe, irq, line_a_in, line_b_in;
  int n_fail = 0;
  int cmp_count = 0;
  // Wire level from whichever party drives each line
  assign line_a_in = a_oe ? a_out : a_pin;
  assign line_b_in = b_oe ? b_out : b_pin;
  initial begin
    forever #50 pclk = ~pclk;
  end
  tcc_channel i_tcc_channel (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_pins(ext_pins), .chain_line_a(chain), .line_a_in(line_a_in),
    .line_a_event(a_event), .line_a_out(a_out), .line_a_oe(a_oe), .line_b_in(line_b_in),
    .line_b_out(b_out), .line_b_oe(b_oe), .irq(irq)
  );
  tcc_far i_tcc_far (
    .pclk(pclk), .ext_clock_pins(ext_pins), .chain_line_a(chain), .line_a_pin(a_pin),
    .line_a_event(a_event), .line_b_pin(b_pin)
  );
  // ********
  // Bus and checking helpers
  // ********
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("mismatch pready expected 1 seen %b", pready);
      print_verdict();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask : rd
  // ********
  // Scenarios
  // ********
  task t_reset;
    rd(OFF_CMR, RST_CMR, "mode");
    rd(OFF_CV, 32'h0, "count");
    rd(OFF_SR, 32'h0, "status");
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    wr(OFF_CMR, 32'hFFFFFFFF);
    rd(OFF_CMR, CMR_MASK, "mode mask");
    chk("wave line a oe", 32'h1, {31'h0, a_oe});
    wr(OFF_CMR, 32'h0);
    wr(OFF_RC, 32'h0000FFFF);
    $display("test reset done");
  endtask : t_reset
  task t_count;
    wr(OFF_CMR, 32'h5);
    wr(OFF_CCR, 32'h1);
    rd(OFF_SR, 32'h00010000, "clock on");
    wr(OFF_BCR, 32'h1);
    i_tcc_far.pulse(0, 5);
    rd(OFF_CV, 32'h4, "group count");
    wr(OFF_CCR, 32'h4);
    i_tcc_far.pulse(0, 3);
    rd(OFF_CV, 32'h2, "soft count");
    wr(OFF_CCR, 32'h3);
    rd(OFF_SR, 32'h0, "clock off");
    wr(OFF_CCR, 32'h4);
    i_tcc_far.pulse(0, 3);
    rd(OFF_CV, 32'h2, "count held");
    $display("test count done");
  endtask : t_count
  task t_clock;
    wr(OFF_CCR, 32'h1);
    wr(OFF_CCR, 32'h4);
    wr(OFF_BMR, 32'h1);
    i_tcc_far.pulse(0, 2);
    rd(OFF_CV, 32'h2, "pin ignored");
    i_tcc_far.pulse(3, 4);
    rd(OFF_CV, 32'h3, "chained count");
    wr(OFF_BMR, 32'h0);
    wr(OFF_CMR, 32'hD);
    wr(OFF_CCR, 32'h4);
    i_tcc_far.pulse(0, 1);
    i_tcc_far.level(0, 1'b1);
    rd(OFF_CV, 32'h0, "inverted rise");
    i_tcc_far.level(0, 1'b0);
    rd(OFF_CV, 32'h1, "inverted fall");
    wr(OFF_CMR, 32'h16);
    i_tcc_far.pulse(1, 2);
    rd(OFF_CV, 32'h1, "gate low");
    i_tcc_far.level(0, 1'b1);
    i_tcc_far.pulse(1, 2);
    rd(OFF_CV, 32'h3, "gate high");
    i_tcc_far.level(0, 1'b0);
    $display("test clock done");
  endtask : t_clock
  task t_capture;
    wr(OFF_CMR, 32'h00090005);
    wr(OFF_CCR, 32'h4);
    i_tcc_far.pulse(0, 3);
    i_tcc_far.pulse(6, 1);
    i_tcc_far.pulse(0, 2);
    i_tcc_far.pulse(8, 1);
    rd(OFF_SR, 32'h0001001A, "capture status");
    rd(OFF_RA, 32'h4, "capture a");
    rd(OFF_RB, 32'h4, "capture b");
    chk("capture oe", 32'h0, {30'h0, a_oe, b_oe});
    wr(OFF_CMR, 32'h00090045);
    wr(OFF_CCR, 32'h4);
    i_tcc_far.pulse(0, 2);
    i_tcc_far.pulse(6, 1);
    i_tcc_far.pulse(0, 2);
    rd(OFF_CV, 32'h1, "stopped");
    rd(OFF_SR, 32'h00010018, "stop status");
    wr(OFF_CMR, 32'h00090085);
    wr(OFF_CCR, 32'h4);
    i_tcc_far.pulse(6, 1);
    rd(OFF_SR, 32'h0000001A, "load disable");
    wr(OFF_CCR, 32'h1);
    $display("test capture done");
  endtask : t_capture
  task t_trigger;
    for (int s = 0; s < 2; s++) begin
      wr(OFF_CMR, 32'h105 | (32'(s) << 10));
      wr(OFF_CCR, 32'h4);
      i_tcc_far.pulse(0, 4);
      i_tcc_far.pulse(s ? 6 : 7, 1);
      rd(OFF_SR, 32'h00010020, "ext trigger");
      i_tcc_far.pulse(0, 1);
      rd(OFF_CV, 32'h0, "ext cleared");
    end
    wr(OFF_IER, 32'h4);
    rd(OFF_IMR, 32'h4, "mask");
    wr(OFF_RC, 32'h3);
    wr(OFF_CMR, 32'h4005);
    wr(OFF_CCR, 32'h4);
    i_tcc_far.pulse(0, 6);
    chk("irq set", 32'h1, {31'h0, irq});
    rd(OFF_SR, 32'h00010004, "compare status");
    rd(OFF_CV, 32'h1, "compare cleared");
    repeat (2) @(posedge pclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("test trigger done");
  endtask : t_trigger
  task t_wave;
    wr(OFF_CMR, 32'h00008000);
    repeat (2) @(posedge pclk);
    chk("wave oe", 32'h3, {30'h0, a_oe, b_oe});
    wr(OFF_CMR, 32'h00009105);
    repeat (2) @(posedge pclk);
    chk("event oe", 32'h2, {30'h0, a_oe, b_oe});
    rd(OFF_SR, 32'h00010004, "wave compare");
    i_tcc_far.pulse(7, 1);
    rd(OFF_SR, 32'h00010020, "wave event");
    $display("test wave done");
  endtask : t_wave
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_count();
    t_clock();
    t_capture();
    t_trigger();
    t_wave();
    print_verdict();
  end
endmodule : tcc_channel_tb_top
